/* hw/hcc_channel_if.sv */
// Word data channel between the coupler (active end) and the processor (passive end).
// Assumes both ends run on the same clock; the testbench joins them.
`default_nettype none

interface hcc_channel_if;
  logic [2:0] b2a_code;
  logic [15:0] b2a_word;
  logic b2a_send;
  logic b2a_fetch;
  logic [15:0] a2b_word;
  logic a2b_valid;
  logic a2b_illegal;

  modport coupler_mp (
    output b2a_code,
    output b2a_word,
    output b2a_send,
    output b2a_fetch,
    input a2b_word,
    input a2b_valid,
    input a2b_illegal
  );

  modport host_mp (
    input b2a_code,
    input b2a_word,
    input b2a_send,
    input b2a_fetch,
    output a2b_word,
    output a2b_valid,
    output a2b_illegal
  );
endinterface

`default_nettype wire

/* hw/hcc_coupler.sv */
// Active coupler end: takes orders from the station control unit channels,
// forwards codes and addresses, and moves words to or from buffer memory.
// Assumes control unit channels and buffer memory share clk_i; memory read
// data follow one cycle after mem_rd_o.
//
// The address map and the strobed register port were left to the implementer.
`default_nettype none
`include "hcc_defs.svh"

// Function
// - Coupler starts every transfer with code, address
// - Transfers move whole 32-bit words only
// - Control unit loads buffer start, end, processor address
// - Buffer transfer ends itself at end address
// - Processor address sent upper five, then sixteen
// - Two halves form a word, first most significant
// - Buffer mode forwards code, then runs alone
// - Buffer block completes without control unit present
// - Control mode: read to input 7, write from 5
// - Control unit moves each half word itself
// - Code 010 writes out; 101, 001 read in
// - Code 000 carries the low address half
// - Code 111 ends the transfer on both ends
// - Illegal codes start nothing, response sets status
// - Coupler sends data code with first half
// - Operation code sits on channel 7 low bits
// - Select bit one buffer, zero control unit
// - Upper address bits come on channel 5
// - Strobe bit latches code, select and address
// - Each coupler answers only its connect code
// - Operation codes go out, responses come back
// - Null code with low address follows op
// - Null code starts buffer mode data movement
module hcc_coupler
  import hcc_pkg::*;
#(
  parameter logic [`HCC_CONNECT_W-1:0] CONNECT_CODE = 4'h1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Channel to processor
  hcc_channel_if.coupler_mp ch,
  // Normal output channels
  input wire logic [15:0] noc5_i,
  input wire logic [15:0] noc6_i,
  input wire logic [15:0] noc7_i,
  input wire logic noc5_wr_i,
  input wire logic nic7_rd_i,
  // Normal input channels
  output logic [15:0] nic5_o,
  output logic [15:0] nic7_o,
  // Buffer memory
  output logic [`HCC_SBU_AW-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i
);

  hcc_dev_s r;
  hcc_dev_s n;
  logic connected;
  logic [2:0] strb;
  logic [2:0] rise;
  logic [2:0] code;
  logic at_end;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = r;
    n.b2a_send = 1'b0;
    n.b2a_fetch = 1'b0;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;
    connected = (noc6_i[`HCC_CONNECT_W-1:0] == CONNECT_CODE);
    strb = {noc6_i[`HCC_N6_START_BIT], noc6_i[`HCC_N6_TERM_BIT], noc6_i[`HCC_N6_FUNC_BIT]}
      & {3{connected}};
    rise = strb & ~r.prev;
    n.prev = strb;
    code = noc7_i[2:0];
    at_end = (r.addr == r.term_addr) && !r.half;
    if (rise[2])
    begin
      n.start_addr = noc7_i[`HCC_SBU_AW-1:0];
    end
    if (rise[1])
    begin
      n.term_addr = noc5_i[`HCC_SBU_AW-1:0];
    end
    case (r.state)
      HCC_BUF_WR:
      begin
        if (at_end)
        begin
          n.b2a_code = `HCC_FC_END;
          n.b2a_word = 16'h0000;
          n.b2a_send = 1'b1;
          n.state = HCC_IDLE;
        end
        else
        begin
          n.mem_rd = 1'b1;
          n.mem_addr = r.addr;
          n.pending = 1'b1;
          n.state = HCC_BUF_WR_WAIT;
        end
      end
      HCC_BUF_WR_WAIT:
      begin
        if (r.pending)
        begin
          n.pending = 1'b0;
        end
        else
        begin
          n.b2a_code = r.half ? `HCC_FC_NULL : `HCC_FC_DATA;
          n.b2a_word = mem_rdata_i;
          n.b2a_send = 1'b1;
          n.addr = r.addr + 15'h0001;
          n.half = ~r.half;
          n.state = HCC_BUF_WR;
        end
      end
      HCC_BUF_RD:
      begin
        if (at_end)
        begin
          n.b2a_code = `HCC_FC_END;
          n.b2a_word = 16'h0000;
          n.b2a_send = 1'b1;
          n.state = HCC_IDLE;
        end
        else
        begin
          n.b2a_fetch = 1'b1;
          n.state = HCC_BUF_RD_WAIT;
        end
      end
      HCC_BUF_RD_WAIT:
      begin
        if (ch.a2b_valid)
        begin
          n.mem_wr = 1'b1;
          n.mem_addr = r.addr;
          n.mem_wdata = ch.a2b_word;
          n.addr = r.addr + 15'h0001;
          n.half = ~r.half;
          n.state = HCC_BUF_RD;
        end
      end
      HCC_CU_WR:
      begin
        if (noc5_wr_i && connected)
        begin
          n.b2a_code = r.half ? `HCC_FC_NULL : `HCC_FC_DATA;
          n.b2a_word = noc5_i;
          n.b2a_send = 1'b1;
          n.half = ~r.half;
        end
      end
      HCC_CU_RD:
      begin
        if (!r.ready && !r.pending)
        begin
          n.b2a_fetch = 1'b1;
          n.pending = 1'b1;
        end
        if (ch.a2b_valid && r.pending)
        begin
          n.nic7 = ch.a2b_word;
          n.ready = 1'b1;
          n.pending = 1'b0;
          n.half = ~r.half;
        end
        if (nic7_rd_i && connected && r.ready)
        begin
          n.ready = 1'b0;
        end
      end
      default:
      begin
        n.state = r.state;
      end
    endcase
    if (rise[0])
    begin
      case (code)
        `HCC_FC_WRITE, `HCC_FC_BLKRD, `HCC_FC_READ:
        begin
          n.sel_buf = noc7_i[`HCC_N7_SEL_BIT];
          n.is_read = (code != `HCC_FC_WRITE);
          n.b2a_code = code;
          n.b2a_word = {11'h000, noc5_i[`HCC_HLP_HI_W-1:0]};
          n.b2a_send = 1'b1;
          n.b2a_fetch = 1'b0;
          n.mem_rd = 1'b0;
          n.mem_wr = 1'b0;
          n.addr = r.start_addr;
          n.half = 1'b0;
          n.pending = 1'b0;
          n.ready = 1'b0;
          n.illegal = 1'b0;
          n.state = HCC_ARMED;
        end
        `HCC_FC_NULL:
        begin
          n.b2a_code = code;
          n.b2a_word = noc5_i;
          n.b2a_send = 1'b1;
          if (r.state == HCC_ARMED)
          begin
            if (r.sel_buf)
            begin
              n.state = r.is_read ? HCC_BUF_RD : HCC_BUF_WR;
            end
            else
            begin
              n.state = r.is_read ? HCC_CU_RD : HCC_CU_WR;
            end
          end
        end
        `HCC_FC_END:
        begin
          n.b2a_code = code;
          n.b2a_word = 16'h0000;
          n.b2a_send = 1'b1;
          n.b2a_fetch = 1'b0;
          n.mem_rd = 1'b0;
          n.mem_wr = 1'b0;
          n.state = HCC_IDLE;
        end
        `HCC_FC_DATA:
        begin
          n.b2a_send = n.b2a_send;
        end
        default:
        begin
          n.b2a_code = code;
          n.b2a_word = 16'h0000;
          n.b2a_send = 1'b1;
          n.b2a_fetch = 1'b0;
          n.mem_rd = 1'b0;
          n.mem_wr = 1'b0;
          n.state = HCC_IDLE;
        end
      endcase
    end
    if (ch.a2b_illegal)
    begin
      n.illegal = 1'b1;
    end
    n.busy = (n.state != HCC_IDLE) && (n.state != HCC_ARMED);
    if (n.sel_buf && n.busy)
    begin
      n.nic7 = {1'b0, n.addr};
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r <= '0;
      r.state <= HCC_IDLE;
    end
    else
    begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ch.b2a_code = r.b2a_code;
  assign ch.b2a_word = r.b2a_word;
  assign ch.b2a_send = r.b2a_send;
  assign ch.b2a_fetch = r.b2a_fetch;
  assign nic5_o = {r.illegal, r.busy, r.sel_buf, r.ready, 12'h000};
  assign nic7_o = r.nic7;
  assign mem_addr_o = r.mem_addr;
  assign mem_rd_o = r.mem_rd;
  assign mem_wr_o = r.mem_wr;
  assign mem_wdata_o = r.mem_wdata;

endmodule

`default_nettype wire

/* hw/hcc_defs.svh */
// Constants for the host channel coupler: function codes, bit positions, widths.
// Assumes inclusion by bare name from the package and both channel ends.
`ifndef HCC_DEFS_SVH
`define HCC_DEFS_SVH

// ****************************************
// Operation function codes
// ****************************************
`define HCC_FC_NULL 3'h0
`define HCC_FC_READ 3'h1
`define HCC_FC_WRITE 3'h2
`define HCC_FC_ILL_A 3'h3
`define HCC_FC_DATA 3'h4
`define HCC_FC_BLKRD 3'h5
`define HCC_FC_ILL_B 3'h6
`define HCC_FC_END 3'h7

// ****************************************
// Normal output channel bit positions
// ****************************************
`define HCC_N6_START_BIT 15
`define HCC_N6_TERM_BIT 14
`define HCC_N6_FUNC_BIT 13
`define HCC_N7_SEL_BIT 3
`define HCC_CONNECT_W 4

// ****************************************
// Normal input channel 5 status bit positions
// ****************************************
`define HCC_N5_ILLEGAL_BIT 15
`define HCC_N5_BUSY_BIT 14
`define HCC_N5_SBU_BIT 13
`define HCC_N5_READY_BIT 12

// ****************************************
// Widths
// ****************************************
`define HCC_HALF_W 16
`define HCC_SBU_AW 15
`define HCC_HLP_AW 21
`define HCC_HLP_HI_W 5

`endif

/* hw/hcc_host_end.sv */
// Passive processor end: holds processor memory, answers codes and fetches.
// Assumes the coupler on the same clock drives the channel interface.
`default_nettype none
`include "hcc_defs.svh"

module hcc_host_end
  import hcc_pkg::*;
#(
  parameter int MEM_AW = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Channel
  hcc_channel_if.host_mp ch,
  // Memory preload and inspection
  input wire logic load_i,
  input wire logic [MEM_AW-1:0] load_addr_i,
  input wire logic [31:0] load_data_i,
  input wire logic [MEM_AW-1:0] peek_addr_i,
  output logic [31:0] peek_data_o,
  output logic [15:0] words_o,
  output logic busy_o
);

  hcc_host_s r;
  hcc_host_s n;
  logic [31:0] mem [0:(1<<MEM_AW)-1];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [31:0] mem_wd;
  logic [31:0] cur;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = r;
    n.a2b_valid = 1'b0;
    n.a2b_illegal = 1'b0;
    mem_we = load_i;
    mem_wa = load_addr_i;
    mem_wd = load_data_i;
    cur = mem[r.addr[MEM_AW-1:0]];
    if (ch.b2a_send)
    begin
      case (ch.b2a_code)
        `HCC_FC_WRITE, `HCC_FC_BLKRD, `HCC_FC_READ:
        begin
          n.state = HCC_H_OP;
          n.is_read = (ch.b2a_code != `HCC_FC_WRITE);
          n.addr = {ch.b2a_word[`HCC_HLP_HI_W-1:0], 16'h0000};
          n.have_hi = 1'b0;
          n.half = 1'b0;
        end
        `HCC_FC_NULL:
        begin
          if (r.state == HCC_H_OP)
          begin
            n.addr[15:0] = ch.b2a_word;
            n.state = r.is_read ? HCC_H_RD : HCC_H_WR;
          end
          else if (r.state == HCC_H_WR && r.have_hi)
          begin
            mem_we = 1'b1;
            mem_wa = r.addr[MEM_AW-1:0];
            mem_wd = {r.hi, ch.b2a_word};
            n.addr = r.addr + 21'h00_0001;
            n.have_hi = 1'b0;
            n.words = r.words + 16'h0001;
          end
        end
        `HCC_FC_DATA:
        begin
          if (r.state == HCC_H_WR)
          begin
            n.hi = ch.b2a_word;
            n.have_hi = 1'b1;
          end
        end
        `HCC_FC_END:
        begin
          n.state = HCC_H_IDLE;
        end
        default:
        begin
          n.a2b_illegal = 1'b1;
          n.state = HCC_H_IDLE;
        end
      endcase
    end
    if (ch.b2a_fetch && r.state == HCC_H_RD)
    begin
      n.a2b_word = r.half ? cur[15:0] : cur[31:16];
      n.a2b_valid = 1'b1;
      n.half = ~r.half;
      if (r.half)
      begin
        n.addr = r.addr + 21'h00_0001;
        n.words = r.words + 16'h0001;
      end
    end
    n.peek = mem[peek_addr_i];
  end

  // ****************************************
  // Registers and memory
  // ****************************************
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r <= '0;
      r.state <= HCC_H_IDLE;
    end
    else
    begin
      r <= n;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (mem_we)
    begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign ch.a2b_word = r.a2b_word;
  assign ch.a2b_valid = r.a2b_valid;
  assign ch.a2b_illegal = r.a2b_illegal;
  assign peek_data_o = r.peek;
  assign words_o = r.words;
  assign busy_o = (r.state != HCC_H_IDLE);

endmodule

`default_nettype wire

/* hw/hcc_pkg.sv */
// Types shared by both ends of the host channel coupler.
// Assumes hcc_defs.svh is on the include path.
`default_nettype none
`include "hcc_defs.svh"

package hcc_pkg;

  // ****************************************
  // Coupler states
  // ****************************************
  typedef enum logic [7:0] {
    HCC_IDLE = 8'h01,
    HCC_ARMED = 8'h02,
    HCC_BUF_WR = 8'h04,
    HCC_BUF_WR_WAIT = 8'h08,
    HCC_BUF_RD = 8'h10,
    HCC_BUF_RD_WAIT = 8'h20,
    HCC_CU_WR = 8'h40,
    HCC_CU_RD = 8'h80
  } hcc_dev_e;

  // ****************************************
  // Processor end states
  // ****************************************
  typedef enum logic [3:0] {
    HCC_H_IDLE = 4'h1,
    HCC_H_OP = 4'h2,
    HCC_H_WR = 4'h4,
    HCC_H_RD = 4'h8
  } hcc_host_e;

  typedef struct packed {
    hcc_dev_e state;
    logic is_read;
    logic sel_buf;
    logic [2:0] prev;
    logic [`HCC_SBU_AW-1:0] start_addr;
    logic [`HCC_SBU_AW-1:0] term_addr;
    logic [`HCC_SBU_AW-1:0] addr;
    logic half;
    logic pending;
    logic ready;
    logic illegal;
    logic busy;
    logic [2:0] b2a_code;
    logic [`HCC_HALF_W-1:0] b2a_word;
    logic b2a_send;
    logic b2a_fetch;
    logic mem_rd;
    logic mem_wr;
    logic [`HCC_SBU_AW-1:0] mem_addr;
    logic [`HCC_HALF_W-1:0] mem_wdata;
    logic [`HCC_HALF_W-1:0] nic7;
  } hcc_dev_s;

  typedef struct packed {
    hcc_host_e state;
    logic is_read;
    logic [`HCC_HLP_AW-1:0] addr;
    logic [`HCC_HALF_W-1:0] hi;
    logic have_hi;
    logic half;
    logic [`HCC_HALF_W-1:0] a2b_word;
    logic a2b_valid;
    logic a2b_illegal;
    logic [31:0] peek;
    logic [15:0] words;
  } hcc_host_s;

endpackage

`default_nettype wire

/* tb/hcc_channel_asserts.sv */
// Checker for the word channel between coupler and processor end.
// Assumes the bench wires it to the interface signals.
`default_nettype none
`include "hcc_defs.svh"

module hcc_channel_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Channel
  input wire logic [2:0] b2a_code,
  input wire logic [15:0] b2a_word,
  input wire logic b2a_send,
  input wire logic b2a_fetch,
  input wire logic [15:0] a2b_word,
  input wire logic a2b_valid,
  input wire logic a2b_illegal
);
  // ****************************************
  // Helper state
  // ****************************************
  logic op_open;
  logic half_open;
  logic [3:0] open_cnt;
  wire logic is_op = b2a_send && (b2a_code == `HCC_FC_WRITE ||
    b2a_code == `HCC_FC_READ || b2a_code == `HCC_FC_BLKRD);
  wire logic is_ill = b2a_code == `HCC_FC_ILL_A || b2a_code == `HCC_FC_ILL_B;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      op_open <= 1'b0;
      half_open <= 1'b0;
      open_cnt <= 4'h0;
    end
    else if (b2a_send)
    begin
      op_open <= is_op;
      half_open <= b2a_code == `HCC_FC_DATA;
      open_cnt <= 4'h0;
    end
    else if (half_open)
      open_cnt <= open_cnt + 4'h1;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_ILL_RESP: assert property (b2a_send && is_ill |=> a2b_illegal)
    else $error("illegal code got no response");
  AST_ILL_ONLY: assert property (a2b_illegal |-> $past(b2a_send) &&
    ($past(b2a_code) == `HCC_FC_ILL_A || $past(b2a_code) == `HCC_FC_ILL_B))
    else $error("illegal response without illegal code");
  AST_FETCH_ANS: assert property (b2a_fetch |=> a2b_valid)
    else $error("fetch not answered");
  AST_VALID_ONLY: assert property (a2b_valid |-> $past(b2a_fetch))
    else $error("word returned without fetch");
  AST_OP_WORD: assert property (is_op |-> b2a_word[15:5] == 11'h000)
    else $error("op word carries more than five bits");
  AST_NULL_AFTER_OP: assert property (b2a_send && op_open |->
    b2a_code == `HCC_FC_NULL)
    else $error("op code not followed by null code");
  AST_SECOND_HALF: assert property (b2a_send && half_open |->
    b2a_code == `HCC_FC_NULL)
    else $error("data half not followed by second half");
  AST_HALF_BOUND: assert property (half_open |-> open_cnt < 4'h8)
    else $error("second half of word overdue");

  CV_END: cover property (b2a_send && b2a_code == `HCC_FC_END);
  CV_ILL: cover property (a2b_illegal);
  CV_FETCH: cover property (b2a_fetch ##1 a2b_valid);
  CV_DATA: cover property (b2a_send && b2a_code == `HCC_FC_DATA);
endmodule

`default_nettype wire

/* tb/tb_host_channel_coupler.sv */
// Bench joining coupler and processor end over the channel.
// Assumes package, defs, interface and both ends compile first.
`default_nettype none
`include "hcc_defs.svh"

module tb_host_channel_coupler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] noc5 = '0, noc6 = '0, noc7 = '0, mem_rdata = '0;
  logic noc5_wr = 1'b0, nic7_rd = 1'b0, load = 1'b0;
  logic [9:0] load_addr = '0, peek_addr = '0;
  logic [31:0] load_data = '0;
  wire logic [15:0] nic5, nic7, mem_wdata, words;
  wire logic [14:0] mem_addr;
  wire logic mem_rd, mem_wr, busy;
  wire logic [31:0] peek;
  logic [15:0] sbuf [0:63];
  int err_count = 0, cmp_count = 0, cyc = 0, sends = 0;

  hcc_channel_if u_hcc_channel_if ();
  hcc_coupler u_hcc_coupler (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ch(u_hcc_channel_if),
    .noc5_i(noc5), .noc6_i(noc6), .noc7_i(noc7), .noc5_wr_i(noc5_wr), .nic7_rd_i(nic7_rd),
    .nic5_o(nic5), .nic7_o(nic7), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
    .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata));
  hcc_host_end u_hcc_host_end (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ch(u_hcc_channel_if),
    .load_i(load), .load_addr_i(load_addr), .load_data_i(load_data),
    .peek_addr_i(peek_addr), .peek_data_o(peek), .words_o(words), .busy_o(busy));
  hcc_channel_asserts u_hcc_channel_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .b2a_code(u_hcc_channel_if.b2a_code), .b2a_word(u_hcc_channel_if.b2a_word),
    .b2a_send(u_hcc_channel_if.b2a_send), .b2a_fetch(u_hcc_channel_if.b2a_fetch),
    .a2b_word(u_hcc_channel_if.a2b_word), .a2b_valid(u_hcc_channel_if.a2b_valid),
    .a2b_illegal(u_hcc_channel_if.a2b_illegal));

  // ****************************************
  // Clock, buffer memory, send counter, timeout
  // ****************************************
  initial
    forever #4 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    sends <= sends + u_hcc_channel_if.b2a_send;
    mem_rdata <= mem_rd ? sbuf[mem_addr[5:0]] : ~mem_rdata;
    if (mem_wr)
      sbuf[mem_addr[5:0]] <= mem_wdata;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic strobe(input logic [2:0] code, input logic sel, input logic [15:0] word,
    input logic [3:0] conn, input int hold);
    noc7 <= {12'h000, sel, code};
    noc5 <= word;
    noc6 <= {12'h200, conn};
    tick(hold);
    noc6 <= 16'h0001;
    tick(2);
  endtask

  task automatic op(input logic [2:0] code, input logic sel, input logic [20:0] a);
    strobe(code, sel, {11'h000, a[20:16]}, 4'h1, 1);
    strobe(`HCC_FC_NULL, sel, a[15:0], 4'h1, 1);
  endtask

  task automatic bounds(input logic [14:0] s, input logic [14:0] t);
    noc7 <= {1'b0, s};
    noc6 <= 16'h8001;
    tick(1);
    noc6 <= 16'h0001;
    noc5 <= {1'b0, t};
    tick(1);
    noc6 <= 16'h4001;
    tick(1);
    noc6 <= 16'h0001;
    tick(1);
  endtask

  task automatic hload(input logic [9:0] a, input logic [31:0] d);
    load <= 1'b1;
    load_addr <= a;
    load_data <= d;
    tick(1);
    load <= 1'b0;
    tick(1);
  endtask

  task automatic peekc(input logic [9:0] a, input logic [31:0] exp);
    peek_addr <= a;
    tick(2);
    check("host word", peek, exp);
  endtask

  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    tick(1);
    while ((b < 0 ? busy : nic5[b]) !== v && n < 200)
    begin
      tick(1);
      n++;
    end
    check("wait", (b < 0) ? busy : nic5[b], v);
    tick(2);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pulses(input logic [2:0] code, input logic [3:0] conn, input int hold,
    input int exp);
    int s0;
    s0 = sends;
    strobe(code, 1'b0, 16'h0000, conn, hold);
    tick(2);
    check("sends", sends - s0, exp);
  endtask

  task automatic t_illegal(input logic [2:0] code);
    t_pulses(code, 4'h1, 1, 1);
    check("illegal", nic5[`HCC_N5_ILLEGAL_BIT], 1'b1);
    check("busy", busy, 1'b0);
  endtask

  task automatic t_buf_write();
    int w0;
    for (int i = 8; i < 14; i++)
      sbuf[i] = 16'h1100 + i;
    hload(10'h006, 32'hDEAD_0006);
    bounds(15'h0008, 15'h000C);
    w0 = words;
    op(`HCC_FC_WRITE, 1'b1, 21'h1_0004);
    check("status", nic5, 16'h6000);
    check("return addr", nic7, 16'h0008);
    noc6 <= 16'h0000;
    wait_bit(-1, 1'b0);
    noc6 <= 16'h0001;
    check("words", words - w0, 2);
    peekc(10'h004, 32'h1108_1109);
    peekc(10'h005, 32'h110A_110B);
    peekc(10'h006, 32'hDEAD_0006);
  endtask

  task automatic t_buf_read(input logic [2:0] code);
    for (int i = 32; i < 36; i++)
      sbuf[i] = 16'h0000;
    sbuf[36] = 16'h5A5A;
    hload(10'h014, 32'hA1A2_A3A4);
    hload(10'h015, 32'hB1B2_B3B4);
    bounds(15'h0020, 15'h0024);
    op(code, 1'b1, 21'h0_0014);
    wait_bit(-1, 1'b0);
    check("buf 32", {sbuf[32], sbuf[33]}, 32'hA1A2_A3A4);
    check("buf 34", {sbuf[34], sbuf[35]}, 32'hB1B2_B3B4);
    check("buf 36", sbuf[36], 16'h5A5A);
  endtask

  task automatic t_cu_write();
    op(`HCC_FC_WRITE, 1'b0, 21'h0_001E);
    for (int i = 1; i < 5; i++)
    begin
      noc5 <= 16'hC000 + i;
      noc5_wr <= 1'b1;
      tick(1);
      noc5_wr <= 1'b0;
      tick(1);
    end
    strobe(`HCC_FC_END, 1'b0, 16'h0000, 4'h1, 1);
    check("busy", busy, 1'b0);
    peekc(10'h01E, 32'hC001_C002);
    peekc(10'h01F, 32'hC003_C004);
  endtask

  task automatic t_cu_read();
    hload(10'h028, 32'hD1D2_D3D4);
    op(`HCC_FC_BLKRD, 1'b0, 21'h0_0028);
    for (int i = 0; i < 2; i++)
    begin
      wait_bit(`HCC_N5_READY_BIT, 1'b1);
      check("nic7", nic7, i ? 16'hD3D4 : 16'hD1D2);
      nic7_rd <= 1'b1;
      tick(1);
      nic7_rd <= 1'b0;
    end
    strobe(`HCC_FC_END, 1'b0, 16'h0000, 4'h1, 1);
    check("busy", busy, 1'b0);
  endtask

  initial
  begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    noc6 <= 16'h0001;
    tick(2);
    t_pulses(`HCC_FC_END, 4'h1, 5, 1);
    t_pulses(`HCC_FC_DATA, 4'h1, 1, 0);
    t_pulses(`HCC_FC_END, 4'h2, 1, 0);
    t_illegal(`HCC_FC_ILL_B);
    t_illegal(`HCC_FC_ILL_A);
    t_buf_write();
    t_buf_read(`HCC_FC_BLKRD);
    t_buf_read(`HCC_FC_READ);
    t_cu_write();
    t_cu_read();
    sys_rst_i <= 1'b1;
    tick(2);
    sys_rst_i <= 1'b0;
    tick(2);
    check("status", nic5, 16'h0000);
    end_of_test();
  end
endmodule

`default_nettype wire
